// >>> src/mfp_pkg.sv
// Purpose: Shared constants and types for the multi-function pin block.
// Assumes: 31 pins over ports 0,1,2,4,5; ports 3 and 6 hold no pins.
// Notes:   Pin n of port p sits at global index PORT_BASE[p] + n.
package mfp_pkg;

  localparam int NUM_PINS  = 31;
  localparam int NUM_PORTS = 7;
  localparam int NUM_ALT   = 3;
  localparam int CFG_W     = 2;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 32;
  localparam int NUM_XI    = 2;

  // Ports 3 and 6 are reserved, hence width zero
  localparam int PORT_WIDTH [8] = '{5, 2, 10, 0, 1, 13, 0, 0};
  localparam int PORT_BASE  [8] = '{0, 5, 7, 17, 17, 18, 31, 31};

  // Function select codes
  localparam logic [1:0] FN_GPIO = 2'h0;
  localparam logic [1:0] FN_ALT1 = 2'h1;
  localparam logic [1:0] FN_ALT2 = 2'h2;
  localparam logic [1:0] FN_ALT3 = 2'h3;

  // Which pins really own an alternate function per code
  localparam logic [30:0] ALT1_AVAIL = 31'h7FFF_FF9F;
  localparam logic [30:0] ALT2_AVAIL = 31'h5FC3_FFFF;
  localparam logic [30:0] ALT3_AVAIL = 31'h0FC0_001F;

  // Interrupt input pins and the code that routes them to the detector
  localparam int         XI_A_PIN  = 0;
  localparam int         XI_B_PIN  = 17;
  localparam logic [1:0] XI_FN     = FN_ALT2;

  // Port register word within a port block, address bits [3:2]
  localparam logic [1:0] SEL_CFG   = 2'h0;
  localparam logic [1:0] SEL_DIR   = 2'h1;
  localparam logic [1:0] SEL_DOUT  = 2'h2;
  localparam logic [1:0] SEL_DIN   = 2'h3;
  localparam logic [4:0] PORT_AREA = 5'h00;

  // Byte offsets of the interrupt registers
  localparam logic [11:0] OFF_XICFG  = 12'h074;
  localparam logic [11:0] OFF_XISTAT = 12'h078;
  localparam logic [11:0] OFF_XICLR  = 12'h07C;
  localparam logic [11:0] OFF_XIEN   = 12'h080;

  // Sensitivity modes, two bits per input in the config register
  localparam logic [1:0] XM_LOW  = 2'h0;
  localparam logic [1:0] XM_HIGH = 2'h1;
  localparam logic [1:0] XM_RISE = 2'h2;
  localparam logic [1:0] XM_FALL = 2'h3;

  // Reset values: port 4 pin starts on its first alternate
  localparam logic [61:0] CFG_RST   = 62'h0000_0004_0000_0000;
  localparam logic [30:0] DIR_RST   = 31'h0000_0000;
  localparam logic [30:0] DOUT_RST  = 31'h0000_0000;
  localparam logic [3:0]  XICFG_RST = 4'h0;
  localparam logic [1:0]  XIEN_RST  = 2'h0;

  typedef struct packed {
    logic [30:0] out;
    logic [30:0] oe;
  } mfp_drive_t;

endpackage

// >>> src/mfp_irq_detect.sv
// Purpose: Level or edge detector for one external interrupt input.
// Assumes: level is already synchronised to ref_clk.
// Notes:   hit is a registered pulse for edges, a held level for levels.
`timescale 1ns/1ns
`default_nettype none
module mfp_irq_detect
(
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       level,
  input  wire logic [1:0] mode,
  input  wire logic       armed,
  output var  logic       hit
);

  logic prevR;
  logic hitNxt;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      prevR <= 1'b0;
    else
      prevR <= level;
  end

  always_comb
  begin
    case (mode)
      mfp_pkg::XM_LOW:  hitNxt = ~level;
      mfp_pkg::XM_HIGH: hitNxt = level;
      mfp_pkg::XM_RISE: hitNxt = level & ~prevR;
      mfp_pkg::XM_FALL: hitNxt = ~level & prevR;
      default:          hitNxt = 1'b0;
    endcase
  end

  // Disarmed pins give no event, so a stale level cannot fire later
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      hit <= 1'b0;
    else
      hit <= hitNxt & armed;
  end

endmodule
`default_nettype wire

// >>> src/mfp_pin_mux.sv
// Purpose: Multi-function pin mux with GPIO, alternates and two ext irqs.
// Assumes: APB slave on ref_clk; pads sampled through two flip-flops.
// Notes:   One wait state on every APB access; outputs are registered.
// How it works
// - Thirty-one pins are grouped into seven ports by peripheral interface.
// - Ports hold 5, 2, 10, 0, 1, 13 and 0 pins.
// - Software configures every pin's function through port registers.
// - Any pin may be a plain general-purpose input/output line.
// - Each pin picks GPIO or up to three alternates; missing ones idle.
// - Both external irq inputs feed the single channel 31 output.
// - Each irq input triggers on low, high, rising or falling edge.
// - A status register shows which irq input raised channel 31.
// - Two-bit code: 00 GPIO, 01/10/11 first, second, third alternate.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module mfp_pin_mux
(
  input  wire logic                         ref_clk,
  input  wire logic                         rst_b,
  input  wire logic [11:0]                  paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output var  logic [31:0]                  prdata,
  output var  logic                         pready,
  output var  logic                         pslverr,
  input  wire logic [30:0]                  padIn,
  output var  logic [30:0]                  padOut,
  output var  logic [30:0]                  padOe,
  input  wire mfp_pkg::mfp_drive_t [2:0]    altDrive,
  output var  logic [30:0]                  periphIn,
  output var  logic [1:0]                   extIrqSourceFlags,
  output var  logic                         irqChan31
);

  logic [61:0] cfgR;
  logic [30:0] dirR;
  logic [30:0] doutR;
  logic [30:0] padMetaR;
  logic [30:0] padSyncR;
  logic [3:0]  xiCfgR;
  logic [1:0]  xiEnR;
  logic [1:0]  xiStatR;
  logic [1:0]  xiHit;
  logic [1:0]  xiArmed;
  logic [1:0]  xiClr;
  logic [31:0] rdNxt;
  logic [30:0] padOutNxt;
  logic [30:0] padOeNxt;
  logic        portArea;
  logic        portHit;
  logic        xiHitAddr;
  logic        addrHit;
  logic        accFirst;
  logic        accDone;
  logic        wrDone;
  logic [2:0]  portSel;
  logic [1:0]  regSel;

  assign portSel   = paddr[6:4];
  assign regSel    = paddr[3:2];
  assign portArea  = (paddr[11:7] == mfp_pkg::PORT_AREA) && (paddr[1:0] == 2'h0);
  // Reserved ports decode as unmapped
  assign portHit   = portArea && (mfp_pkg::PORT_WIDTH[portSel] != 0);
  assign xiHitAddr = (paddr == mfp_pkg::OFF_XICFG) || (paddr == mfp_pkg::OFF_XISTAT)
                  || (paddr == mfp_pkg::OFF_XICLR) || (paddr == mfp_pkg::OFF_XIEN);
  assign addrHit   = portHit || xiHitAddr;
  assign accFirst  = psel & penable & ~pready;
  assign accDone   = psel & penable & pready;
  assign wrDone    = accDone & pwrite & addrHit;

  // APB answer: one wait state, data and error settled with pready
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= accFirst;
      pslverr <= accFirst & ~addrHit;
      prdata  <= (accFirst & ~pwrite) ? rdNxt : 32'h0000_0000;
    end
  end

  // Read mux; unused and reserved bits read as zero
  always_comb
  begin
    int base;
    int width;
    base  = mfp_pkg::PORT_BASE[portSel];
    width = mfp_pkg::PORT_WIDTH[portSel];
    rdNxt = 32'h0000_0000;
    if (portHit)
    begin
      for (int j = 0; j < 13; j++)
      begin
        if (j < width)
        begin
          case (regSel)
            mfp_pkg::SEL_CFG:  rdNxt[2*j +: 2] = cfgR[2*(base+j) +: 2];
            mfp_pkg::SEL_DIR:  rdNxt[j]        = dirR[base+j];
            mfp_pkg::SEL_DOUT: rdNxt[j]        = doutR[base+j];
            mfp_pkg::SEL_DIN:  rdNxt[j]        = padSyncR[base+j];
            default:           rdNxt[j]        = 1'b0;
          endcase
        end
      end
    end
    else if (paddr == mfp_pkg::OFF_XICFG)
      rdNxt[3:0] = xiCfgR;
    else if (paddr == mfp_pkg::OFF_XISTAT)
      rdNxt[1:0] = xiStatR;
    else if (paddr == mfp_pkg::OFF_XIEN)
      rdNxt[1:0] = xiEnR;
  end

  // Port registers, written only at the completing edge
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfgR  <= mfp_pkg::CFG_RST;
      dirR  <= mfp_pkg::DIR_RST;
      doutR <= mfp_pkg::DOUT_RST;
    end
    else if (wrDone && portHit)
    begin
      for (int j = 0; j < 13; j++)
      begin
        if (j < mfp_pkg::PORT_WIDTH[portSel])
        begin
          case (regSel)
            mfp_pkg::SEL_CFG:
              cfgR[2*(mfp_pkg::PORT_BASE[portSel]+j) +: 2] <= pwdata[2*j +: 2];
            mfp_pkg::SEL_DIR:
              dirR[mfp_pkg::PORT_BASE[portSel]+j] <= pwdata[j];
            mfp_pkg::SEL_DOUT:
              doutR[mfp_pkg::PORT_BASE[portSel]+j] <= pwdata[j];
            default:
              ;
          endcase
        end
      end
    end
  end

  // Interrupt config and enable
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      xiCfgR <= mfp_pkg::XICFG_RST;
      xiEnR  <= mfp_pkg::XIEN_RST;
    end
    else if (wrDone)
    begin
      if (paddr == mfp_pkg::OFF_XICFG)
        xiCfgR <= pwdata[3:0];
      if (paddr == mfp_pkg::OFF_XIEN)
        xiEnR <= pwdata[1:0];
    end
  end

  // All pads pass two flops; only the second stage is read anywhere
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      padMetaR <= 31'h0000_0000;
      padSyncR <= 31'h0000_0000;
    end
    else
    begin
      padMetaR <= padIn;
      padSyncR <= padMetaR;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      periphIn <= 31'h0000_0000;
    else
      periphIn <= padSyncR;
  end

  // Function mux per pin
  always_comb
  begin
    padOutNxt = 31'h0000_0000;
    padOeNxt  = 31'h0000_0000;
    for (int i = 0; i < mfp_pkg::NUM_PINS; i++)
    begin
      case (cfgR[2*i +: 2])
        mfp_pkg::FN_GPIO:
        begin
          padOutNxt[i] = doutR[i];
          padOeNxt[i]  = dirR[i];
        end
        mfp_pkg::FN_ALT1:
        begin
          padOutNxt[i] = altDrive[0].out[i] & mfp_pkg::ALT1_AVAIL[i];
          padOeNxt[i]  = altDrive[0].oe[i]  & mfp_pkg::ALT1_AVAIL[i];
        end
        mfp_pkg::FN_ALT2:
        begin
          padOutNxt[i] = altDrive[1].out[i] & mfp_pkg::ALT2_AVAIL[i];
          padOeNxt[i]  = altDrive[1].oe[i]  & mfp_pkg::ALT2_AVAIL[i];
        end
        mfp_pkg::FN_ALT3:
        begin
          padOutNxt[i] = altDrive[2].out[i] & mfp_pkg::ALT3_AVAIL[i];
          padOeNxt[i]  = altDrive[2].oe[i]  & mfp_pkg::ALT3_AVAIL[i];
        end
        default:
        begin
          padOutNxt[i] = 1'b0;
          padOeNxt[i]  = 1'b0;
        end
      endcase
    end
    // Irq pins set to the irq code XI_FN are pure inputs; never drive them then
    if (cfgR[2*mfp_pkg::XI_A_PIN +: 2] == mfp_pkg::XI_FN)
      padOeNxt[mfp_pkg::XI_A_PIN] = 1'b0;
    if (cfgR[2*mfp_pkg::XI_B_PIN +: 2] == mfp_pkg::XI_FN)
      padOeNxt[mfp_pkg::XI_B_PIN] = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      padOut <= 31'h0000_0000;
      padOe  <= 31'h0000_0000;
    end
    else
    begin
      padOut <= padOutNxt;
      padOe  <= padOeNxt;
    end
  end

  // Ext irq A on port 0 pin 0, B on the port 4 wait-request pin
  assign xiArmed[0] = (cfgR[2*mfp_pkg::XI_A_PIN +: 2] == mfp_pkg::XI_FN);
  assign xiArmed[1] = (cfgR[2*mfp_pkg::XI_B_PIN +: 2] == mfp_pkg::XI_FN);

  mfp_irq_detect uDetA
  (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .level   (padSyncR[mfp_pkg::XI_A_PIN]),
    .mode    (xiCfgR[1:0]),
    .armed   (xiArmed[0]),
    .hit     (xiHit[0])
  );

  mfp_irq_detect uDetB
  (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .level   (padSyncR[mfp_pkg::XI_B_PIN]),
    .mode    (xiCfgR[3:2]),
    .armed   (xiArmed[1]),
    .hit     (xiHit[1])
  );

  assign xiClr = (wrDone && (paddr == mfp_pkg::OFF_XICLR)) ? pwdata[1:0] : 2'h0;

  // Sticky source flags; a new hit wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      xiStatR <= 2'h0;
    else
      xiStatR <= (xiStatR & ~xiClr) | xiHit;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irqChan31         <= 1'b0;
      extIrqSourceFlags <= 2'h0;
    end
    else
    begin
      irqChan31         <= |(xiStatR & xiEnR);
      extIrqSourceFlags <= xiStatR;
    end
  end

endmodule
`default_nettype wire

// >>> testbench/mfp_pin_mux_monitor.sv
// Purpose: Port-level checks on the pin mux.
// Assumes: One clock, async active-low reset.
// Notes:   Bound to every mfp_pin_mux.
`timescale 1ns/1ns
`default_nettype none
module mfp_pin_mux_monitor
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [30:0] padIn,
  input wire logic [30:0] periphIn,
  input wire logic [1:0]  extIrqSourceFlags,
  input wire logic        irqChan31
);
  logic [1:0] upCnt_r;
  // Synchroniser holds stale zeros for three edges after reset
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      upCnt_r <= 2'h0;
    else if (upCnt_r != 2'h3)
      upCnt_r <= upCnt_r + 2'h1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_bound_a: assert property (psel && penable && !pready |-> ##[1:2] pready)
    else $error("access phase too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");
  reserved_port_a: assert property (pready && paddr[11:4] inside {8'h03, 8'h06}
    |-> pslverr)
    else $error("reserved port not refused");
  status_mapped_a: assert property (pready && paddr == mfp_pkg::OFF_XISTAT |-> !pslverr)
    else $error("status access refused");
  // Request and flags are launched from the same status edge
  irq_cause_a: assert property (irqChan31 |-> extIrqSourceFlags != 2'h0)
    else $error("irq without a source flag");
  // Clear lands in status, then one more edge to reach the flag output
  flag_clear_a: assert property ($fell(extIrqSourceFlags[0]) |->
    $past(pready && pwrite && paddr == mfp_pkg::OFF_XICLR && pwdata[0], 2))
    else $error("source flag dropped without clear");
  periph_sync_a: assert property (upCnt_r == 2'h3 |-> periphIn == $past(padIn, 3))
    else $error("periphIn not three edges behind padIn");
endmodule
bind mfp_pin_mux mfp_pin_mux_monitor i_mon (.ref_clk, .rst_b, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .padIn, .periphIn, .extIrqSourceFlags,
  .irqChan31);
`default_nettype wire

// >>> testbench/mfp_board_model.sv
// Purpose: Board pads and peripherals around the pin mux.
// Assumes: Undriven pads settle at the board level.
// Notes:   Each alternate drives a fixed pattern.
`timescale 1ns/1ns
`default_nettype none
module mfp_board_model
(
  input  wire logic [30:0]               padOut,
  input  wire logic [30:0]               padOe,
  input  wire logic [30:0]               boardLvl,
  output var  logic [30:0]               padIn,
  output var  mfp_pkg::mfp_drive_t [2:0] altDrive
);
  assign padIn = (padOut & padOe) | (boardLvl & ~padOe);
  assign altDrive = {31'h0F0F_0F0F, 31'h7FFF_FFFF, 31'h5555_5555, 31'h7FFF_FFFF,
                     31'h2AAA_AAAA, 31'h7FFF_FFFF};
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Purpose: Self-checking bench for the pin mux.
// Assumes: APB master here; board model owns pads.
// Notes:   Alternate patterns make routing visible.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic                      ref_clk = 1'b0;
  logic                      rst_b = 1'b0;
  logic [11:0]               paddr = 12'h000;
  logic                      psel = 1'b0;
  logic                      penable = 1'b0;
  logic                      pwrite = 1'b0;
  logic [31:0]               pwdata = 32'h0;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic [30:0]               padIn;
  logic [30:0]               padOut;
  logic [30:0]               padOe;
  logic [30:0]               boardLvl = 31'h0;
  mfp_pkg::mfp_drive_t [2:0] altDrive;
  logic [30:0]               periphIn;
  logic [1:0]                flags;
  logic                      irq;
  logic [31:0]               rd;
  logic                      err;
  int                        fails = 0;
  int                        n_compared = 0;
  localparam logic [30:0] PAT [3] = '{31'h2AAA_AAAA, 31'h5555_5555, 31'h0F0F_0F0F};
  localparam logic [30:0] AV [3] = '{mfp_pkg::ALT1_AVAIL, mfp_pkg::ALT2_AVAIL,
                                     mfp_pkg::ALT3_AVAIL};
  localparam int          PORTS [5] = '{0, 1, 2, 4, 5};
  always #5 ref_clk = ~ref_clk;
  mfp_pin_mux i_dut (.ref_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .padIn, .padOut, .padOe, .altDrive, .periphIn,
    .extIrqSourceFlags(flags), .irqChan31(irq));
  mfp_board_model i_board (.padOut, .padOe, .boardLvl, .padIn, .altDrive);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // No assumed latency; only the watchdog ends a stuck wait
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_reset;
    apb(1'b0, 12'h040, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_gpio;
    logic [30:0] eo;
    eo = 31'h0;
    foreach (PORTS[i])
    begin
      apb(1'b1, 12'(PORTS[i] * 16), 32'h0);
      apb(1'b1, 12'(PORTS[i] * 16 + 4), 32'hFFFF_FFFF);
      apb(1'b1, 12'(PORTS[i] * 16 + 8), 32'h5555_5555);
      eo |= (31'h5555_5555 & ((31'h1 << mfp_pkg::PORT_WIDTH[PORTS[i]]) - 31'h1))
            << mfp_pkg::PORT_BASE[PORTS[i]];
    end
    repeat (3) @(posedge ref_clk);
    chk(32'(padOe), 32'h7FFF_FFFF);
    chk(32'(padOut), 32'(eo));
    apb(1'b0, 12'h058, 32'h0);
    chk(rd, 32'h0000_1555);
    boardLvl <= 31'h0000_0016;
    apb(1'b1, 12'h004, 32'h0);
    repeat (4) @(posedge ref_clk);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h16);
  endtask
  task automatic t_alt;
    logic [30:0] m;
    for (int k = 1; k <= 3; k++)
    begin
      foreach (PORTS[i])
        apb(1'b1, 12'(PORTS[i] * 16), {16{2'(k)}});
      repeat (3) @(posedge ref_clk);
      // Interrupt pins on code 10 are inputs only
      m = (k == 2) ? ~31'h0002_0001 : 31'h7FFF_FFFF;
      chk(32'(padOe & m), 32'(AV[k - 1] & m));
      chk(32'(padOut & m), 32'(PAT[k - 1] & AV[k - 1] & m));
    end
  endtask
  task automatic t_unmap;
    apb(1'b0, 12'h030, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, 12'h060, 32'h0);
    chk(32'(err), 32'h1);
  endtask
  task automatic t_irq;
    logic lvl;
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b1, 12'h040, 32'h2);
    apb(1'b1, mfp_pkg::OFF_XIEN, 32'h3);
    for (int m = 0; m < 4; m++)
    begin
      lvl = (m == 0 || m == 3);
      boardLvl <= {13'h0, lvl, 16'h0, lvl};
      apb(1'b1, mfp_pkg::OFF_XICFG, {28'h0, 2'(m), 2'(m)});
      repeat (6) @(posedge ref_clk);
      apb(1'b1, mfp_pkg::OFF_XICLR, 32'h3);
      repeat (2) @(posedge ref_clk);
      chk({30'h0, flags}, 32'h0);
      boardLvl <= {13'h0, !lvl, 16'h0, !lvl};
      repeat (8) @(posedge ref_clk);
      chk({29'h0, irq, flags}, 32'h7);
    end
    apb(1'b0, mfp_pkg::OFF_XISTAT, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, mfp_pkg::OFF_XIEN, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk({29'h0, irq, flags}, 32'h3);
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_gpio();
    t_alt();
    t_unmap();
    t_irq();
    results();
  end
  // Whole run needs well under 2000 cycles
  initial
  begin
    #100000;
    fails++;
    results();
  end
endmodule
`default_nettype wire
